/* File: core/dtc_top.sv */
// Dual timer/counter with Wishbone register port and interrupt
// Operation
// - Timer function counts one per machine cycle of six clocks.
// - Counter function counts falling edges on its own count pin.
// - Each count pin is sampled once per machine cycle; high then low.
// - Detected edge shows in the count during the next machine cycle.
// - Edge recognition takes two machine cycles; max rate clock over twelve.
// - Source bit clear picks machine cycles, set picks the pin.
// - Each counter has a two-bit mode field choosing four modes.
// - Modes 0..2 match for both counters; mode 3 differs.
// - With gate set, count only while irq pin high and run set.
// - Optional toggle of each count pin on its counter overflow.
// - Mode 0: 13-bit count of high byte and low five bits.
// - Mode 1: full 16-bit cascaded counter, no prescaler.
// - Mode 2: low byte counts, reloads from unchanged high byte.
// - Mode 3 splits counter 0; high byte uses counter 1 run/flag.
//
// The Wishbone register port was decided locally.
module dtc_top (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic count_pin_zero_i,
  output logic count_pin_zero_o,
  output logic count_pin_zero_oe,
  input wire logic count_pin_one_i,
  output logic count_pin_one_o,
  output logic count_pin_one_oe,
  input wire logic ext_irq_pin_zero,
  input wire logic ext_irq_pin_one,
  input wire logic [1:0] irq_ack,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] mode;
    logic [3:0] ctrl;
    logic [15:0] cnt0;
    logic [15:0] cnt1;
    logic [1:0] stat;
    logic [1:0] mask;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic [1:0] pin_o;
    logic [1:0] pin_oe;
  } dtc_state_s;

  typedef struct packed {
    logic [15:0] val;
    logic ovf;
  } dtc_step_s;

  dtc_state_s q;
  dtc_state_s d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // One counting step of a counter in the given mode
  function automatic dtc_step_s step(
    input dtc_pkg::dtc_mode_e m,
    input logic [15:0] v,
    input logic inc
  );
    dtc_step_s r;
    logic [12:0] c13;
    r.val = v;
    r.ovf = 1'b0;
    c13 = {v[15:8], v[4:0]} + 13'h0001;
    if (inc)
    begin
      unique case (m)
        dtc_pkg::MODE_13:
        begin
          r.val = {c13[12:5], v[7:5], c13[4:0]};
          r.ovf = &{v[15:8], v[4:0]};
        end
        dtc_pkg::MODE_16:
        begin
          r.val = v + 16'h0001;
          r.ovf = &v;
        end
        dtc_pkg::MODE_RELOAD:
        begin
          r.ovf = &v[7:0];
          r.val = r.ovf ? {v[15:8], v[15:8]}
                        : {v[15:8], v[7:0] + 8'h01};
        end
        dtc_pkg::MODE_SPLIT:
        begin
          r.ovf = &v[7:0];
          r.val = {v[15:8], v[7:0] + 8'h01};
        end
      endcase
    end
    return r;
  endfunction : step

  // Byte-lane merge of a write into an older word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction : merge

  // Read data of a register index; unmapped reads as zero
  function automatic logic [31:0] rd(
    input logic [9:0] idx,
    input dtc_state_s s
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (idx)
      dtc_pkg::IDX_MODE: r[7:0] = s.mode;
      dtc_pkg::IDX_CTRL: r[3:0] = s.ctrl;
      dtc_pkg::IDX_CNT0: r[15:0] = s.cnt0;
      dtc_pkg::IDX_CNT1: r[15:0] = s.cnt1;
      dtc_pkg::IDX_STAT: r[1:0] = s.stat;
      dtc_pkg::IDX_MASK: r[1:0] = s.mask;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : rd

  // ----------------------------------------------------------------
  // Machine-cycle tick and pin sampling
  // ----------------------------------------------------------------
  dtc_evt_if ev ();

  dtc_div u_div (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ev(ev)
  );

  // sample then count a cycle later
  dtc_pins u_pins (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pin({ext_irq_pin_one, ext_irq_pin_zero,
          count_pin_one_i, count_pin_zero_i}),
    .ev(ev)
  );

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  dtc_pkg::dtc_mode_e m0;
  dtc_pkg::dtc_mode_e m1;
  logic src0;
  logic src1;
  logic gate0;
  logic gate1;
  logic run0;
  logic run1;
  logic split;

  assign m0 = dtc_pkg::dtc_mode_e'(q.mode[dtc_pkg::MODE0_LSB +: 2]);
  assign m1 = dtc_pkg::dtc_mode_e'(q.mode[dtc_pkg::MODE1_LSB +: 2]);
  assign src0 = q.mode[dtc_pkg::SRC0_BIT];
  assign src1 = q.mode[dtc_pkg::SRC1_BIT];
  assign gate0 = q.mode[dtc_pkg::GATE0_BIT];
  assign gate1 = q.mode[dtc_pkg::GATE1_BIT];
  assign run0 = q.ctrl[dtc_pkg::RUN0_BIT];
  assign run1 = q.ctrl[dtc_pkg::RUN1_BIT];
  // mode 3 special only for counter 0
  assign split = (m0 == dtc_pkg::MODE_SPLIT);

  // ----------------------------------------------------------------
  // Count enables
  // ----------------------------------------------------------------
  logic pulse0;
  logic pulse1;
  logic inc0;
  logic inc1;
  logic inc_hi;

  // edge mark counts at next tick
  assign pulse0 = ev.tick & (~src0 | ev.fall[dtc_pkg::PIN_CNT0]);
  assign pulse1 = ev.tick & (~src1 | ev.fall[dtc_pkg::PIN_CNT1]);

  assign inc0 = pulse0 & run0
              & (~gate0 | ev.lvl[dtc_pkg::PIN_IRQ0]);
  assign inc1 = pulse1 & run1
              & (~gate1 | ev.lvl[dtc_pkg::PIN_IRQ1])
              & (m1 != dtc_pkg::MODE_SPLIT);

  // high byte counts cycles on run 1
  assign inc_hi = ev.tick & run1 & split;

  // ----------------------------------------------------------------
  // Counter steps
  // ----------------------------------------------------------------
  dtc_step_s r0;
  dtc_step_s r1;
  logic ovf_hi;
  logic [1:0] ovf;

  assign r0 = step(m0, q.cnt0, inc0);
  assign r1 = step(m1, q.cnt1, inc1);
  assign ovf_hi = inc_hi & (&q.cnt0[15:8]);

  // split high byte owns flag 1
  // Counter 1 may still run, but without a flag, while split
  assign ovf[0] = r0.ovf;
  assign ovf[1] = split ? ovf_hi : r1.ovf;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic [9:0] idx;

  // Classic cycle, one wait state; no ack while the previous shows
  assign req = wb_cyc_i & wb_stb_i & ~q.ack;
  assign wr = req & wb_we_i;
  assign idx = wb_adr_i[11:2];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [31:0] wcnt0;
  logic [31:0] wcnt1;
  logic [31:0] wmisc;
  logic [1:0] clr;

  always_comb
  begin
    d = q;
    wcnt0 = 32'h0000_0000;
    wcnt1 = 32'h0000_0000;
    wmisc = 32'h0000_0000;
    clr = irq_ack;

    d.cnt0 = r0.val;
    d.cnt1 = r1.val;
    if (inc_hi)
      d.cnt0[15:8] = q.cnt0[15:8] + 8'h01;

    // Software writes to a count win over a same-cycle step
    if (wr && idx == dtc_pkg::IDX_CNT0)
    begin
      wcnt0 = merge({16'h0000, d.cnt0}, wb_dat_i, wb_sel_i);
      d.cnt0 = wcnt0[15:0];
    end
    if (wr && idx == dtc_pkg::IDX_CNT1)
    begin
      wcnt1 = merge({16'h0000, d.cnt1}, wb_dat_i, wb_sel_i);
      d.cnt1 = wcnt1[15:0];
    end

    // Mode, control and mask registers, and status write-one-to-clear
    if (wr && idx == dtc_pkg::IDX_MODE)
    begin
      wmisc = merge({24'h000000, q.mode}, wb_dat_i, wb_sel_i);
      d.mode = wmisc[7:0];
    end
    if (wr && idx == dtc_pkg::IDX_CTRL && wb_sel_i[0])
      d.ctrl = wb_dat_i[3:0];
    if (wr && idx == dtc_pkg::IDX_MASK && wb_sel_i[0])
      d.mask = wb_dat_i[1:0];
    if (wr && idx == dtc_pkg::IDX_STAT && wb_sel_i[0])
      clr = clr | wb_dat_i[1:0];

    d.stat = (q.stat & ~clr) | ovf;
    d.irq = |(d.stat & d.mask);

    d.pin_oe = {q.ctrl[dtc_pkg::TOG1_BIT],
                q.ctrl[dtc_pkg::TOG0_BIT]};
    if (q.ctrl[dtc_pkg::TOG0_BIT] && r0.ovf)
      d.pin_o[0] = ~q.pin_o[0];
    if (q.ctrl[dtc_pkg::TOG1_BIT] && r1.ovf)
      d.pin_o[1] = ~q.pin_o[1];

    // Answer every request, mapped or not, one clock later
    d.ack = req;
    d.dat = (req && !wb_we_i) ? rd(idx, q) : 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.mode <= dtc_pkg::MODE_RST;
      q.ctrl <= dtc_pkg::CTRL_RST;
      q.cnt0 <= dtc_pkg::CNT_RST;
      q.cnt1 <= dtc_pkg::CNT_RST;
      q.stat <= dtc_pkg::FLAG_RST;
      q.mask <= dtc_pkg::FLAG_RST;
    end
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign irq = q.irq;
  assign count_pin_zero_o = q.pin_o[0];
  assign count_pin_one_o = q.pin_o[1];
  assign count_pin_zero_oe = q.pin_oe[0];
  assign count_pin_one_oe = q.pin_oe[1];

endmodule : dtc_top

/* File: core/dtc_pkg.sv */
// Package: register map, field layout and timing of the dual timer
package dtc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS = 100;
  localparam logic [2:0] MC_CLKS = 3'h6;
  localparam logic [2:0] MC_LAST = MC_CLKS - 3'h1;

  // ----------------------------------------------------------------
  // Register word indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_MODE = 10'h089;
  localparam logic [9:0] IDX_CTRL = 10'h08A;
  localparam logic [9:0] IDX_CNT0 = 10'h08B;
  localparam logic [9:0] IDX_CNT1 = 10'h08C;
  localparam logic [9:0] IDX_STAT = 10'h08D;
  localparam logic [9:0] IDX_MASK = 10'h08E;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int GATE1_BIT = 7;
  localparam int SRC1_BIT = 6;
  localparam int MODE1_LSB = 4;
  localparam int GATE0_BIT = 3;
  localparam int SRC0_BIT = 2;
  localparam int MODE0_LSB = 0;

  // Control register fields
  localparam int RUN0_BIT = 0;
  localparam int RUN1_BIT = 1;
  localparam int TOG0_BIT = 2;
  localparam int TOG1_BIT = 3;

  // Pin slots of the sampled inputs
  localparam int PIN_CNT0 = 0;
  localparam int PIN_CNT1 = 1;
  localparam int PIN_IRQ0 = 2;
  localparam int PIN_IRQ1 = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [1:0] FLAG_RST = 2'h0;

  typedef enum logic [1:0] {
    MODE_13,
    MODE_16,
    MODE_RELOAD,
    MODE_SPLIT
  } dtc_mode_e;

endpackage : dtc_pkg

/* File: core/dtc_evt_if.sv */
// Interface: machine-cycle tick and sampled pin events
interface dtc_evt_if;
  logic tick;
  logic [3:0] lvl;
  logic [3:0] fall;
  modport div (output tick);
  modport pins (input tick, output lvl, output fall);
  modport core (input tick, input lvl, input fall);
endinterface : dtc_evt_if

/* File: core/dtc_div.sv */
// Machine-cycle divider: one tick every six clocks
module dtc_div (
  input wire logic clk_sys,
  input wire logic resetn,
  dtc_evt_if.div ev
);
  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
  } dtc_div_s;

  dtc_div_s q;
  dtc_div_s d;

  // Free-running count, tick on the last clock of each cycle
  always_comb
  begin
    d = q;
    d.tick = (q.cnt == dtc_pkg::MC_LAST);
    d.cnt = d.tick ? 3'h0 : q.cnt + 3'h1;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= d;
  end

  assign ev.tick = q.tick;
endmodule : dtc_div

/* File: core/dtc_pins.sv */
// Pin sampler: synchroniser, glitch filter and falling-edge detect
module dtc_pins (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] pin,
  dtc_evt_if.pins ev
);
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] lvl;
    logic [3:0] smp;
    logic [3:0] fall;
  } dtc_pins_s;

  dtc_pins_s q;
  dtc_pins_s d;

  // Level changes only once two late stages agree
  always_comb
  begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));
    if (ev.tick)
    begin
      d.smp = q.lvl;
      d.fall = q.smp & ~q.lvl;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= d;
  end

  assign ev.lvl = q.lvl;
  assign ev.fall = q.fall;
endmodule : dtc_pins

/* File: sim/dtc_sva.sv */
// Checker: bus, read width and pin timing of the dual timer
module dtc_sva (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic count_pin_zero_o,
  input wire logic count_pin_zero_oe,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Read strobe and word index, held by the master up to ack
  wire rd = wb_ack_o && !wb_we_i;
  wire [9:0] ix = wb_adr_i[11:2];

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_idle: assert property (!wb_cyc_i && !wb_ack_o |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");

  // ----------------------------------------------------------------
  // Read widths
  // ----------------------------------------------------------------
  a_mode_width: assert property (rd && ix == 10'h089
    |-> wb_dat_o[31:8] == 24'h0)
    else $error("mode read too wide");
  a_cnt_width: assert property (rd && (ix == 10'h08B || ix == 10'h08C)
    |-> wb_dat_o[31:16] == 16'h0)
    else $error("count read too wide");
  a_flag_width: assert property (rd && (ix == 10'h08D || ix == 10'h08E)
    |-> wb_dat_o[31:2] == 30'h0)
    else $error("flag read too wide");
  a_unmap_zero: assert property (rd && (ix < 10'h089 || ix > 10'h08E)
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");

  // Overflow steps fall on ticks, so toggles are at least six clocks apart
  a_tog_spacing: assert property ($changed(count_pin_zero_o)
    |=> $stable(count_pin_zero_o) [*5])
    else $error("toggle closer than a machine cycle");
  a_reset_quiet: assert property ($rose(resetn)
    |-> !irq && !count_pin_zero_oe && !wb_ack_o)
    else $error("output active right after reset");

  cover property (wb_ack_o && wb_we_i);
  cover property ($rose(irq));
  cover property ($changed(count_pin_zero_o));
endmodule : dtc_sva

bind dtc_top dtc_sva u_sva (.clk_sys, .resetn, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .count_pin_zero_o,
  .count_pin_zero_oe, .irq);

/* File: sim/dtc_pin_src.sv */
// Partner model: external event source on one count pin
module dtc_pin_src (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic en,
  input wire logic [7:0] hold,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] n_q;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      n_q <= 8'h00;
      pin <= 1'b1; // Pulled up while idle
    end
    else if (!en)
    begin
      n_q <= 8'h00;
      pin <= 1'b1;
    end
    else if (n_q == hold - 8'h01)
    begin
      n_q <= 8'h00;
      pin <= ~pin;
    end
    else
      n_q <= n_q + 8'h01;
  end
endmodule : dtc_pin_src

/* File: sim/test_dual_timer_counter.sv */
// Testbench of the dual timer/counter
module test_dual_timer_counter;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] MODE = 12'h224;
  localparam logic [11:0] CTRL = 12'h228;
  localparam logic [11:0] C0 = 12'h22C;
  localparam logic [11:0] C1 = 12'h230;
  localparam logic [11:0] ST = 12'h234;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0;
  logic [1:0] iack = 2'h0;
  logic [1:0] gate = 2'h0;
  logic [1:0] src_en = 2'h0;
  logic [31:0] rdat, v, a, b;
  wire logic [1:0] src;
  wire logic [1:0] po;
  wire logic [1:0] poe;
  logic [1:0] pin;
  logic ack, irq, po0_q;
  logic [7:0] v8;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int ntog = 0;

  // Count pin wire: the block wins while it drives
  assign pin = (poe & po) | (~poe & src);

  dtc_pin_src p0 (.clk_sys, .resetn, .en(src_en[0]), .hold(8'h06),
    .pin(src[0]));
  dtc_pin_src p1 (.clk_sys, .resetn, .en(src_en[1]), .hold(8'h0A),
    .pin(src[1]));
  dtc_top uut (.clk_sys, .resetn, .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'hF),
    .wb_dat_o(rdat), .wb_ack_o(ack), .count_pin_zero_i(pin[0]),
    .count_pin_zero_o(po[0]), .count_pin_zero_oe(poe[0]),
    .count_pin_one_i(pin[1]), .count_pin_one_o(po[1]),
    .count_pin_one_oe(poe[1]), .ext_irq_pin_zero(gate[0]),
    .ext_irq_pin_one(gate[1]), .irq_ack(iack), .irq);

  always #50 clk_sys = ~clk_sys;

  // Toggle counting and the hang guard
  always @(posedge clk_sys)
  begin
    po0_q <= po[0];
    // Updated late so a task reading it at an edge sees a settled count
    ntog <= ntog + int'(po[0] !== po0_q);
    cycles++;
    if (cycles == 8000)
    begin
      n_fail++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Bus, compare and report
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [11:0] ad,
    input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= ad;
    wd <= d;
    @(posedge clk_sys);
    while (ack !== 1'b1) @(posedge clk_sys);
    v = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rc(input logic [11:0] ad, input logic [31:0] exp);
    wb(1'b0, ad, 32'h0);
    chk(v, exp);
  endtask : rc

  // Two reads whose taking edges lie exactly 60 clocks apart
  task automatic meas(input logic [11:0] ad);
    wb(1'b0, ad, 32'h0);
    a = v;
    repeat (57) @(posedge clk_sys);
    wb(1'b0, ad, 32'h0);
    b = v;
  endtask : meas

  task automatic final_report;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // reset values, access
  task automatic t_regs;
    for (int i = 0; i < 6; i++)
      rc(MODE + 12'(4 * i), 32'h0);
    wb(1'b1, MODE, 32'hFFFFFFFF);
    rc(MODE, 32'hFF);
    wb(1'b1, 12'h300, 32'h1);
    rc(12'h300, 32'h0);
    wb(1'b1, MODE, 32'h0);
  endtask : t_regs

  task automatic t_timer;
    wb(1'b1, 12'h238, 32'h1);
    wb(1'b1, MODE, 32'h1);
    wb(1'b1, C0, 32'hFFFC);
    wb(1'b1, CTRL, 32'h1);
    meas(C0);
    wb(1'b1, CTRL, 32'h0);
    chk(b[15:0], 16'(a[15:0] + 16'h000A));
    chk(irq, 1'b1);
    wb(1'b1, 12'h238, 32'h0);
    rc(ST, 32'h1);
    chk(irq, 1'b0);
    wb(1'b1, ST, 32'h1);
    rc(ST, 32'h0);
  endtask : t_timer

  task automatic t_mode0;
    wb(1'b1, MODE, 32'h0);
    wb(1'b1, C0, 32'h00FC);
    wb(1'b1, CTRL, 32'h1);
    meas(C0);
    wb(1'b1, CTRL, 32'h0);
    chk({b[15:8], b[4:0]}, 13'({a[15:8], a[4:0]} + 13'h000A));
    chk(b[7:5], 3'h7);
  endtask : t_mode0

  task automatic t_reload;
    wb(1'b1, MODE, 32'h2);
    wb(1'b1, C0, 32'hF0FC);
    wb(1'b1, CTRL, 32'h1);
    meas(C0);
    wb(1'b1, CTRL, 32'h0);
    v8 = a[7:0];
    repeat (10) v8 = (v8 == 8'hFF) ? 8'hF0 : v8 + 8'h01;
    chk(b[15:0], {8'hF0, v8});
  endtask : t_reload

  task automatic t_split;
    wb(1'b1, ST, 32'h3);
    wb(1'b1, MODE, 32'h33);
    wb(1'b1, C0, 32'hFC05);
    wb(1'b1, C1, 32'h1234);
    wb(1'b1, CTRL, 32'h2);
    meas(C0);
    wb(1'b1, CTRL, 32'h0);
    chk(b[15:0], {a[15:8] + 8'h0A, 8'h05});
    rc(C1, 32'h1234);
    rc(ST, 32'h2);
    iack <= 2'h2;
    @(posedge clk_sys);
    iack <= 2'h0;
    rc(ST, 32'h0);
  endtask : t_split

  task automatic t_gate;
    wb(1'b1, MODE, 32'h09);
    wb(1'b1, C0, 32'h0);
    wb(1'b1, CTRL, 32'h1);
    meas(C0);
    chk(b, a);
    gate <= 2'h1;
    repeat (6) @(posedge clk_sys);
    meas(C0);
    chk(b[15:0], a[15:0] + 16'h000A);
    wb(1'b1, CTRL, 32'h0);
    gate <= 2'h0;
  endtask : t_gate

  // pin edges, fast and slow source
  task automatic t_count;
    wb(1'b1, MODE, 32'h05);
    wb(1'b1, CTRL, 32'h1);
    src_en <= 2'h1;
    repeat (24) @(posedge clk_sys);
    meas(C0);
    chk(b[15:0] - a[15:0], 32'h5);
    wb(1'b1, MODE, 32'h50);
    wb(1'b1, CTRL, 32'h2);
    src_en <= 2'h2;
    repeat (24) @(posedge clk_sys);
    meas(C1);
    chk(b[15:0] - a[15:0], 32'h3);
    wb(1'b1, CTRL, 32'h0);
    src_en <= 2'h0;
  endtask : t_count

  task automatic t_toggle;
    wb(1'b1, MODE, 32'h02);
    wb(1'b1, C0, 32'hFFFF);
    wb(1'b1, CTRL, 32'h5);
    repeat (12) @(posedge clk_sys);
    chk(poe, 2'h1);
    a = 32'(ntog);
    repeat (60) @(posedge clk_sys);
    chk(32'(ntog) - a, 32'hA);
    wb(1'b1, CTRL, 32'h8);
    repeat (3) @(posedge clk_sys);
    chk(poe, 2'h2);
  endtask : t_toggle

  initial
  begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs();
    t_timer();
    t_mode0();
    t_reload();
    t_split();
    t_gate();
    t_count();
    t_toggle();
    final_report();
  end
endmodule : test_dual_timer_counter
